/* src/shr_pkg.sv */
// Constants, types and field layout for the status register hierarchy.
// Assumes one clock domain and a command port driven by the query parser.
package shr_pkg;

    // ------------------------------------------------------------
    // Widths and set selection
    // ------------------------------------------------------------
    localparam int SHR_W = 16;
    localparam int SHR_NSETS = 5;
    localparam logic [2:0] SET_OPER = 3'h0;
    localparam logic [2:0] SET_INST = 3'h1;
    localparam logic [2:0] SET_TRIG = 3'h2;
    localparam logic [2:0] SET_SYST = 3'h3;
    localparam logic [2:0] SET_QUES = 3'h4;

    // ------------------------------------------------------------
    // Register selection within a set
    // ------------------------------------------------------------
    localparam logic [2:0] REG_COND = 3'h0;
    localparam logic [2:0] REG_EVENT = 3'h1;
    localparam logic [2:0] REG_ENABLE = 3'h2;
    localparam logic [2:0] REG_RISE = 3'h3;
    localparam logic [2:0] REG_FALL = 3'h4;

    // ------------------------------------------------------------
    // Reset, preset and mask values
    // ------------------------------------------------------------
    localparam logic [15:0] MASK_LEGAL = 16'h7fff;
    localparam logic [15:0] RST_ENABLE = 16'h0000;
    localparam logic [15:0] RST_RISE = 16'h7fff;
    localparam logic [15:0] RST_FALL = 16'h0000;
    localparam logic [15:0] RST_EVENT = 16'h0000;
    localparam logic [15:0] PRE_ENABLE = 16'h7fff;
    localparam logic [15:0] PRE_RISE = 16'h7fff;
    localparam logic [15:0] PRE_FALL = 16'h0000;

    // ------------------------------------------------------------
    // Bit positions
    // ------------------------------------------------------------
    localparam int OPER_CALIBRATING_BIT = 0;
    localparam int OPER_SWEEP_ACTIVE_BIT = 3;
    localparam int OPER_TRIGGER_SUMMARY_BIT = 5;
    localparam int OPER_SYSTEM_SUMMARY_BIT = 12;
    localparam int OPER_INSTRUMENT_SUMMARY_BIT = 13;
    localparam int OPER_SCRIPT_ACTIVE_BIT = 14;
    localparam int INST_FREEZE_BIT = 2;
    localparam int TRIG_MTONE_WAIT1_BIT = 3;
    localparam int TRIG_MTONE_WAIT2_BIT = 4;
    localparam int TRIG_SCOPE_HIT1_BIT = 5;
    localparam int TRIG_SCOPE_HIT2_BIT = 6;
    localparam int SYST_MEDIA_BIT = 1;
    localparam int SYST_SPOOL_BIT = 3;
    localparam int SYST_SOUND_BIT = 4;
    localparam int SYST_CONTACT_BIT = 5;
    localparam int SYST_KEYBOARD_BIT = 6;
    localparam int SYST_PRESPOOL_BIT = 7;
    localparam int QUES_OVERHEAT_BIT = 4;
    localparam int QUES_INPUT_SUMMARY_BIT = 9;
    localparam int QUES_SOURCE_SUMMARY_BIT = 11;
    localparam int QUES_NINPUTS = 11;
    localparam int QUES_NSOURCES = 7;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] set_sel;
        logic [2:0] reg_sel;
        logic [15:0] data;
    } shr_cmd_t;

    typedef struct packed {
        logic calibrating;
        logic sweep_active;
        logic script_active;
        logic [1:0] mtone_wait;
        logic [1:0] scope_hit;
        logic [1:0] scope_waiting;
        logic freeze_active;
        logic media_in;
        logic spooling;
        logic prespooling;
        logic sound_playing;
        logic contact_in;
        logic keyboard_in;
        logic overheat;
        logic [10:0] input_flags;
        logic [6:0] source_flags;
    } shr_live_t;

    typedef logic [15:0] shr_word_t;

endpackage

/* src/shr_set.sv */
// One status register set: condition, rise and fall filters, event, enable.
// Assumes read and write strobes are single-cycle pulses from the top.
`timescale 1ns/10ps
module shr_set #(
    parameter bit CLR_COND_ON_READ = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Live condition word
    input wire shr_pkg::shr_word_t live,
    // Access strobes
    input wire logic wr_en,
    input wire logic [2:0] wr_reg,
    input wire shr_pkg::shr_word_t wr_data,
    input wire logic rd_event,
    input wire logic rd_cond,
    input wire logic preset,
    // Register contents
    output shr_pkg::shr_word_t cond,
    output shr_pkg::shr_word_t event_w,
    output shr_pkg::shr_word_t enable,
    output shr_pkg::shr_word_t rise_filter,
    output shr_pkg::shr_word_t fall_filter,
    output logic summary
);
    import shr_pkg::*;

    shr_word_t prev_q, prev_d;
    shr_word_t cond_q, cond_d;
    shr_word_t event_q, event_d;
    shr_word_t enable_q, enable_d;
    shr_word_t rise_q, rise_d;
    shr_word_t fall_q, fall_d;
    shr_word_t went_up, went_down;

    always_comb begin
        went_up = live & ~prev_q;
        went_down = ~live & prev_q;
        prev_d = live;
        if (CLR_COND_ON_READ) begin
            // A cleared bit comes back only on a new rising edge of its input
            if (rd_cond) begin
                cond_d = went_up;
            end else begin
                cond_d = (cond_q & live) | went_up;
            end
        end else begin
            cond_d = live;
        end
        // New events win over the clear of a read in the same cycle
        event_d = (event_q & ~({SHR_W{rd_event}}))
            | (rise_q & went_up)
            | (fall_q & went_down);
        enable_d = enable_q;
        rise_d = rise_q;
        fall_d = fall_q;
        if (preset) begin
            enable_d = PRE_ENABLE;
            rise_d = PRE_RISE;
            fall_d = PRE_FALL;
        end else if (wr_en) begin
            if (wr_reg == REG_ENABLE) begin
                enable_d = wr_data & MASK_LEGAL;
            end else if (wr_reg == REG_RISE) begin
                rise_d = wr_data & MASK_LEGAL;
            end else if (wr_reg == REG_FALL) begin
                fall_d = wr_data & MASK_LEGAL;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_q <= 16'h0000;
            cond_q <= 16'h0000;
            event_q <= RST_EVENT;
            enable_q <= RST_ENABLE;
            rise_q <= RST_RISE;
            fall_q <= RST_FALL;
        end else begin
            prev_q <= prev_d;
            cond_q <= cond_d;
            event_q <= event_d;
            enable_q <= enable_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
        end
    end

    assign cond = cond_q;
    assign event_w = event_q;
    assign enable = enable_q;
    assign rise_filter = rise_q;
    assign fall_filter = fall_q;
    assign summary = |(event_q & enable_q);

endmodule // shr_set

/* src/shr_cond_map.sv */
// Maps live instrument states and child summaries into condition words.
// Assumes child summaries come straight from child set flip-flops.
`timescale 1ns/10ps
module shr_cond_map (
    // Live states
    input wire shr_pkg::shr_live_t live,
    // Child summaries
    input wire logic inst_summary,
    input wire logic trig_summary,
    input wire logic syst_summary,
    // Condition words
    output shr_pkg::shr_word_t oper_w,
    output shr_pkg::shr_word_t inst_w,
    output shr_pkg::shr_word_t trig_w,
    output shr_pkg::shr_word_t syst_w,
    output shr_pkg::shr_word_t ques_w
);
    import shr_pkg::*;

    always_comb begin
        oper_w = 16'h0000;
        inst_w = 16'h0000;
        trig_w = 16'h0000;
        syst_w = 16'h0000;
        ques_w = 16'h0000;
        oper_w[OPER_CALIBRATING_BIT] = live.calibrating;
        oper_w[OPER_SWEEP_ACTIVE_BIT] = live.sweep_active;
        oper_w[OPER_TRIGGER_SUMMARY_BIT] = trig_summary;
        oper_w[OPER_SYSTEM_SUMMARY_BIT] = syst_summary;
        oper_w[OPER_INSTRUMENT_SUMMARY_BIT] = inst_summary;
        oper_w[OPER_SCRIPT_ACTIVE_BIT] = live.script_active;
        inst_w[INST_FREEZE_BIT] = live.freeze_active;
        trig_w[TRIG_MTONE_WAIT1_BIT] = live.mtone_wait[0];
        trig_w[TRIG_MTONE_WAIT2_BIT] = live.mtone_wait[1];
        // Triggered is forced clear while the channel waits for a trigger
        trig_w[TRIG_SCOPE_HIT1_BIT] = live.scope_hit[0] & ~live.scope_waiting[0];
        trig_w[TRIG_SCOPE_HIT2_BIT] = live.scope_hit[1] & ~live.scope_waiting[1];
        syst_w[SYST_MEDIA_BIT] = live.media_in;
        syst_w[SYST_SPOOL_BIT] = live.spooling;
        syst_w[SYST_SOUND_BIT] = live.sound_playing;
        syst_w[SYST_CONTACT_BIT] = live.contact_in;
        syst_w[SYST_KEYBOARD_BIT] = live.keyboard_in;
        // Prespooling ends once spooling begins
        syst_w[SYST_PRESPOOL_BIT] = live.prespooling & ~live.spooling;
        ques_w[QUES_OVERHEAT_BIT] = live.overheat;
        ques_w[QUES_INPUT_SUMMARY_BIT] = |live.input_flags;
        ques_w[QUES_SOURCE_SUMMARY_BIT] = |live.source_flags;
    end

endmodule // shr_cond_map

/* src/shr_status_top.sv */
// Status register hierarchy: five register sets with summary roll-up.
// Assumes a query parser drives the command port with one-cycle requests.
//
// Operation
// - Sets are 16 bits; written masks are limited to 0..32767.
// - Reading the instrument event register returns it, then clears it.
// - Reading the instrument condition register returns it and clears it.
// - An enabled event bit going true raises the parent summary bit.
// - Rise filter bit set: condition rising sets the event bit.
// - Fall filter bit set: condition falling sets the event bit.
// - Operation bits: calibration 0, sweep 3, trigger 5, system 12, instrument 13, script 14.
// - Instrument condition bit 2 reports freeze active.
// - Script-active condition holds while a script function runs.
// - Trigger bits: multitone wait 3 and 4, scope triggered 5 and 6.
// - Scope triggered bit set on trigger, clear while waiting.
// - Sweep bit follows sweep running; calibration bit follows calibration.
// - System bits: media 1, spooling 3, sound 4, remote sense 5.
// - Spooling follows print job; prespooling ends when spooling starts.
// - Remote-sense bit follows the contact-closure input.
// - Media bit follows media presence; keyboard bit follows keyboard.
// - Questionable bits: over-temperature 4, input 9, source 11.
// - Over-temperature bit set while excess temperature is sensed.
// - Input summary from inputs 1..11, source summary from sources 1..7.
// - Reading the operation condition register leaves it unchanged.
// - Preset sets enables to ones, restores filters, keeps events.
`timescale 1ns/10ps
module shr_status_top (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Live instrument states
    input wire shr_pkg::shr_live_t LIVE,
    // Command port
    input wire shr_pkg::shr_cmd_t CMD,
    input wire logic PRESET,
    // Response port
    output logic RSP_VALID,
    output shr_pkg::shr_word_t RSP_DATA,
    // Summaries
    output logic OPER_SUMMARY,
    output logic QUES_SUMMARY
);
    import shr_pkg::*;

    // ------------------------------------------------------------
    // Set wiring
    // ------------------------------------------------------------
    shr_word_t live_w [SHR_NSETS];
    shr_word_t cond_w [SHR_NSETS];
    shr_word_t event_w [SHR_NSETS];
    shr_word_t enable_w [SHR_NSETS];
    shr_word_t rise_w [SHR_NSETS];
    shr_word_t fall_w [SHR_NSETS];
    logic [SHR_NSETS-1:0] summary_w;
    logic [SHR_NSETS-1:0] sel_w;
    logic is_read;
    logic is_write;

    assign is_read = CMD.valid & ~CMD.write;
    assign is_write = CMD.valid & CMD.write;

    shr_cond_map u_map (
        .live(LIVE),
        .inst_summary(summary_w[SET_INST]),
        .trig_summary(summary_w[SET_TRIG]),
        .syst_summary(summary_w[SET_SYST]),
        .oper_w(live_w[SET_OPER]),
        .inst_w(live_w[SET_INST]),
        .trig_w(live_w[SET_TRIG]),
        .syst_w(live_w[SET_SYST]),
        .ques_w(live_w[SET_QUES])
    );

    // ------------------------------------------------------------
    // Register sets
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < SHR_NSETS; gi++) begin : g_set
            assign sel_w[gi] = (CMD.set_sel == 3'(gi));
            shr_set #(
                .CLR_COND_ON_READ(gi == int'(SET_INST))
            ) u_set (
                .clk(SYS_CLK),
                .rstn(RSTN),
                .live(live_w[gi]),
                .wr_en(is_write & sel_w[gi]),
                .wr_reg(CMD.reg_sel),
                .wr_data(CMD.data),
                .rd_event(is_read & sel_w[gi] & (CMD.reg_sel == REG_EVENT)),
                .rd_cond(is_read & sel_w[gi] & (CMD.reg_sel == REG_COND)),
                .preset(PRESET),
                .cond(cond_w[gi]),
                .event_w(event_w[gi]),
                .enable(enable_w[gi]),
                .rise_filter(rise_w[gi]),
                .fall_filter(fall_w[gi]),
                .summary(summary_w[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Response and summary outputs
    // ------------------------------------------------------------
    logic rsp_valid_q, rsp_valid_d;
    shr_word_t rsp_data_q, rsp_data_d;
    logic oper_sum_q, oper_sum_d;
    logic ques_sum_q, ques_sum_d;
    shr_word_t picked;

    always_comb begin
        picked = 16'h0000;
        for (int i = 0; i < SHR_NSETS; i++) begin
            if (sel_w[i]) begin
                if (CMD.reg_sel == REG_COND) begin
                    picked = cond_w[i];
                end else if (CMD.reg_sel == REG_EVENT) begin
                    picked = event_w[i];
                end else if (CMD.reg_sel == REG_ENABLE) begin
                    picked = enable_w[i];
                end else if (CMD.reg_sel == REG_RISE) begin
                    picked = rise_w[i];
                end else if (CMD.reg_sel == REG_FALL) begin
                    picked = fall_w[i];
                end
            end
        end
        rsp_valid_d = is_read;
        rsp_data_d = is_read ? picked : rsp_data_q;
        oper_sum_d = summary_w[SET_OPER];
        ques_sum_d = summary_w[SET_QUES];
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 16'h0000;
            oper_sum_q <= 1'b0;
            ques_sum_q <= 1'b0;
        end else begin
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q <= rsp_data_d;
            oper_sum_q <= oper_sum_d;
            ques_sum_q <= ques_sum_d;
        end
    end

    assign RSP_VALID = rsp_valid_q;
    assign RSP_DATA = rsp_data_q;
    assign OPER_SUMMARY = oper_sum_q;
    assign QUES_SUMMARY = ques_sum_q;

endmodule // shr_status_top

/* test/shr_status_asserts.sv */
// Port checker for the status register hierarchy.
// Assumes it is bound to shr_status_top and sees only its ports.
`timescale 1ns/10ps
module shr_status_asserts (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Inputs
    input wire shr_pkg::shr_live_t LIVE,
    input wire shr_pkg::shr_cmd_t CMD,
    input wire logic PRESET,
    // Outputs
    input wire logic RSP_VALID,
    input wire shr_pkg::shr_word_t RSP_DATA,
    input wire logic OPER_SUMMARY,
    input wire logic QUES_SUMMARY
);
    import shr_pkg::*;
    logic [1:0] up_q;
    logic rd;
    logic ready;
    assign rd = CMD.valid && !CMD.write;
    assign ready = (up_q == 2'h3);
    // Skips the first edges, where reset edge history makes rises
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            up_q <= 2'h0;
        end else if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    sequence rd_twice(logic [2:0] s, logic [2:0] r);
        (rd && CMD.set_sel == s && CMD.reg_sel == r && $stable(LIVE) && ready)
        ##1 (!CMD.valid && $stable(LIVE))
        ##1 (rd && CMD.set_sel == s && CMD.reg_sel == r && $stable(LIVE));
    endsequence
    a_rsp_pulse: assert property (RSP_VALID == $past(rd))
        else $error("read response pulse wrong");
    a_data_holds: assert property (!RSP_VALID |-> $stable(RSP_DATA))
        else $error("response data moved without a read");
    a_mask_bit15: assert property (rd && CMD.reg_sel >= REG_ENABLE |=> !RSP_DATA[15])
        else $error("mask bit 15 read back set");
    a_bad_select: assert property (rd && CMD.set_sel > SET_QUES |=> RSP_DATA == 16'h0000)
        else $error("unmapped set read not zero");
    a_event_clear: assert property (rd_twice(SET_INST, REG_EVENT) |=> RSP_DATA == 16'h0000)
        else $error("instrument event not cleared by read");
    a_cond_clear: assert property (rd_twice(SET_INST, REG_COND) |=> RSP_DATA == 16'h0000)
        else $error("instrument condition not cleared by read");
    a_oper_keep: assert property (rd_twice(SET_OPER, REG_COND) |=>
        ((RSP_DATA ^ $past(RSP_DATA)) & 16'hcfdf) == 16'h0000)
        else $error("operation condition changed by read");
    a_ques_hold: assert property (QUES_SUMMARY &&
        !$past(CMD.valid && CMD.set_sel == SET_QUES) |=> QUES_SUMMARY)
        else $error("questionable summary dropped without access");
    a_preset_enable: assert property (PRESET ##1 (!CMD.valid) ##1
        (rd && CMD.reg_sel == REG_ENABLE && CMD.set_sel <= SET_QUES) |=> RSP_DATA == PRE_ENABLE)
        else $error("enable after preset wrong");
    a_syst_map: assert property (rd && CMD.set_sel == SET_SYST &&
        CMD.reg_sel == REG_COND && $stable(LIVE) && ready |=> {RSP_DATA[5:3], RSP_DATA[1]} ==
        $past({LIVE.contact_in, LIVE.sound_playing, LIVE.spooling, LIVE.media_in}))
        else $error("system condition bits wrong");
    a_trig_map: assert property (rd && CMD.set_sel == SET_TRIG &&
        CMD.reg_sel == REG_COND && $stable(LIVE) && ready |=> RSP_DATA[6:3] ==
        $past({LIVE.scope_hit & ~LIVE.scope_waiting, LIVE.mtone_wait}))
        else $error("trigger condition bits wrong");
    c_event_read: cover property (rd_twice(SET_INST, REG_EVENT));
    c_oper_rise: cover property ($rose(OPER_SUMMARY));
    c_preset: cover property (PRESET);
endmodule // shr_status_asserts
bind shr_status_top shr_status_asserts shr_status_asserts_inst (.SYS_CLK(SYS_CLK),
    .RSTN(RSTN), .LIVE(LIVE), .CMD(CMD), .PRESET(PRESET), .RSP_VALID(RSP_VALID),
    .RSP_DATA(RSP_DATA), .OPER_SUMMARY(OPER_SUMMARY), .QUES_SUMMARY(QUES_SUMMARY));

/* test/shr_ctrl_model.sv */
// Remote controller model issuing one-cycle read and write requests.
// Assumes the status block answers a read on the following cycle.
`timescale 1ns/10ps
module shr_ctrl_model (
    // Clock
    input wire logic clk,
    // Command and response
    output shr_pkg::shr_cmd_t cmd,
    input wire logic rsp_valid,
    input wire shr_pkg::shr_word_t rsp_data
);
    import shr_pkg::*;
    initial cmd = '0;
    // Released data is inverted so a stale value is never mistaken
    task automatic req(input logic w, input logic [2:0] s, input logic [2:0] r,
                       input shr_word_t d, output shr_word_t q);
        int n;
        q = 'x;
        @(posedge clk);
        cmd <= '{valid: 1'b1, write: w, set_sel: s, reg_sel: r, data: d};
        @(posedge clk);
        cmd <= '{valid: 1'b0, write: 1'b0, set_sel: s, reg_sel: r, data: ~d};
        #1;
        for (n = 0; n < 3 && !w; n++) begin
            if (rsp_valid === 1'b1) begin
                q = rsp_data;
                break;
            end
            @(posedge clk);
            #1;
        end
    endtask
endmodule // shr_ctrl_model

/* test/testbench.sv */
// Self-checking bench for the status register hierarchy.
// Assumes shr_ctrl_model drives the command port on behalf of the bench.
`timescale 1ns/10ps
module testbench;
    import shr_pkg::*;
    logic sys_clk, rstn, preset, rsp_valid, oper_sum, ques_sum;
    shr_live_t live;
    shr_cmd_t cmd;
    shr_word_t rsp_data;
    int fails = 0;
    int n_compared = 0;
    shr_status_top shr_status_top_inst (.SYS_CLK(sys_clk), .RSTN(rstn), .LIVE(live),
        .CMD(cmd), .PRESET(preset), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
        .OPER_SUMMARY(oper_sum), .QUES_SUMMARY(ques_sum));
    shr_ctrl_model shr_ctrl_model_inst (.clk(sys_clk), .cmd(cmd), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data));
    // ----
    // Tasks
    // ----
    task automatic chk(input shr_word_t got, input shr_word_t exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [2:0] s, input logic [2:0] r, input shr_word_t exp);
        shr_word_t q;
        shr_ctrl_model_inst.req(1'b0, s, r, 16'h0000, q);
        chk(q, exp);
        // A read that never answered has been counted; end the run at once
        if ($isunknown(q)) begin
            final_report();
        end
    endtask
    task automatic wr(input logic [2:0] s, input logic [2:0] r, input shr_word_t d);
        shr_word_t q;
        shr_ctrl_model_inst.req(1'b1, s, r, d, q);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // ----
    // Sequence
    // ----
    initial begin
        int s;
        rstn = 1'b0;
        preset = 1'b0;
        live = '0;
        tick(8);
        rstn <= 1'b1;
        for (s = 0; s < SHR_NSETS; s++) begin
            rdc(3'(s), REG_ENABLE, RST_ENABLE);
            rdc(3'(s), REG_RISE, RST_RISE);
            rdc(3'(s), REG_FALL, RST_FALL);
        end
        wr(SET_QUES, REG_ENABLE, 16'hffff);
        rdc(SET_QUES, REG_ENABLE, MASK_LEGAL);
        rdc(3'h5, REG_ENABLE, 16'h0000);
        wr(SET_QUES, REG_ENABLE, 16'h0010);
        @(posedge sys_clk) live.overheat <= 1'b1;
        tick(4);
        chk({15'h0000, ques_sum}, 16'h0001);
        rdc(SET_QUES, REG_EVENT, 16'h0010);
        rdc(SET_QUES, REG_EVENT, 16'h0000);
        tick(3);
        chk({15'h0000, ques_sum}, 16'h0000);
        wr(SET_QUES, REG_RISE, 16'h0000);
        wr(SET_QUES, REG_FALL, 16'h0010);
        @(posedge sys_clk) live.overheat <= 1'b0;
        tick(4);
        rdc(SET_QUES, REG_EVENT, 16'h0010);
        @(posedge sys_clk) live.overheat <= 1'b1;
        tick(4);
        rdc(SET_QUES, REG_EVENT, 16'h0000);
        wr(SET_QUES, REG_RISE, 16'h7fff);
        @(posedge sys_clk) {live.input_flags, live.source_flags} <= 18'h20001;
        tick(4);
        rdc(SET_QUES, REG_COND, 16'h0a10);
        rdc(SET_QUES, REG_EVENT, 16'h0a00);
        $display("questionable set done");
        @(posedge sys_clk) live.freeze_active <= 1'b1;
        tick(4);
        rdc(SET_INST, REG_COND, 16'h0004);
        rdc(SET_INST, REG_COND, 16'h0000);
        rdc(SET_INST, REG_EVENT, 16'h0004);
        rdc(SET_INST, REG_EVENT, 16'h0000);
        $display("instrument set done");
        @(posedge sys_clk) {live.calibrating, live.sweep_active, live.script_active} <= 3'h7;
        tick(4);
        rdc(SET_OPER, REG_COND, 16'h4009);
        rdc(SET_OPER, REG_COND, 16'h4009);
        @(posedge sys_clk) live.sweep_active <= 1'b0;
        tick(4);
        rdc(SET_OPER, REG_COND, 16'h4001);
        wr(SET_TRIG, REG_ENABLE, 16'h0008);
        wr(SET_OPER, REG_ENABLE, 16'h0020);
        @(posedge sys_clk) live.mtone_wait <= 2'b01;
        tick(5);
        chk({15'h0000, oper_sum}, 16'h0001);
        rdc(SET_OPER, REG_EVENT, 16'h4029);
        tick(3);
        chk({15'h0000, oper_sum}, 16'h0000);
        rdc(SET_TRIG, REG_EVENT, 16'h0008);
        @(posedge sys_clk) live.scope_hit <= 2'b11;
        tick(4);
        rdc(SET_TRIG, REG_COND, 16'h0068);
        @(posedge sys_clk) live.scope_waiting <= 2'b10;
        tick(4);
        rdc(SET_TRIG, REG_COND, 16'h0028);
        $display("operation and trigger sets done");
        @(posedge sys_clk) {live.media_in, live.spooling, live.sound_playing, live.contact_in,
            live.keyboard_in, live.prespooling} <= 6'h3f;
        tick(4);
        rdc(SET_SYST, REG_COND, 16'h007a);
        @(posedge sys_clk) {live.spooling, live.contact_in} <= 2'h0;
        tick(4);
        rdc(SET_SYST, REG_COND, 16'h00d2);
        // Condition and event words refuse writes
        wr(SET_SYST, REG_COND, 16'h0001);
        wr(SET_SYST, REG_EVENT, 16'h0101);
        rdc(SET_SYST, REG_COND, 16'h00d2);
        @(posedge sys_clk) preset <= 1'b1;
        @(posedge sys_clk) preset <= 1'b0;
        rdc(SET_SYST, REG_ENABLE, PRE_ENABLE);
        rdc(SET_SYST, REG_RISE, PRE_RISE);
        rdc(SET_TRIG, REG_FALL, PRE_FALL);
        rdc(SET_SYST, REG_EVENT, 16'h00fa);
        $display("system set and preset done");
        final_report();
    end
endmodule // testbench
